// ==== tb/cwt_timer_properties.sv ====
// port checker for the compare waveform block
`timescale 1ns/1ps
module cwt_timer_checker #(
   parameter int unsigned NUM_CH  = 8,
   parameter int unsigned COUNT_W = 16
) (
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire logic              clkEn,
   input wire logic              baseTimerTick,
   input wire logic [7:0]        regAddr,
   input wire logic [31:0]       regWrData,
   input wire logic              regWrEn,
   input wire logic              regRdEn,
   input wire logic [31:0]       regRdData,
   input wire logic [NUM_CH-1:0] compareOutputPin,
   input wire logic [NUM_CH-1:0] compareOutputEn
);
   localparam logic [NUM_CH-1:0] ODD = {(NUM_CH / 2){2'b10}};
   logic [NUM_CH-1:0] enQ, fsQ, srQ, phQ;
   logic [3:0]        ctlQ;
   logic [1:0]        quietQ;
   logic              wr;
   assign wr = regWrEn && clkEn;
   // shadows count as settled three live edges after a write, covering the output pipe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {enQ, fsQ, srQ, phQ, ctlQ, quietQ} <= '0;
      end else begin
         if (wr)
            quietQ <= 2'h0;
         else if (clkEn && quietQ != 2'h3)
            quietQ <= quietQ + 2'h1;
         if (wr && regAddr == cwt_pkg::ENABLE_OFS) enQ <= regWrData[NUM_CH-1:0];
         if (wr && regAddr == cwt_pkg::FUNC_SEL_OFS) fsQ <= regWrData[NUM_CH-1:0];
         if (wr && regAddr == cwt_pkg::BASE_CTL_OFS) ctlQ <= regWrData[3:0];
         if (wr && (regAddr & cwt_pkg::BANK_MASK) == cwt_pkg::OUT_CTL_BASE
             && regAddr[1:0] == 2'h0) begin
            srQ[regAddr[4:2]] <= regWrData[1:0] == cwt_pkg::CWT_MODE_SR;
            phQ[regAddr[4:2]] <= regWrData[1:0] == cwt_pkg::CWT_MODE_PHASE;
         end
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_rst_off; $past(reset) && $past(clkEn) |-> (compareOutputEn | compareOutputPin) == '0;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("outputs not cleared");
   property p_freeze; !clkEn |=> $stable(compareOutputPin) && $stable(compareOutputEn);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
   property p_idle_hold; !baseTimerTick && !regWrEn ##1 !baseTimerTick && !regWrEn
      |=> $stable(compareOutputPin); endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("pin moved without tick");
   property p_en_phase; quietQ == 2'h3 |-> ((enQ ^ compareOutputEn) & phQ & ~fsQ) == '0;
   endproperty
   a_en_phase: assert property (p_en_phase) else $error("enable not followed");
   property p_count_step; regRdEn && regAddr == cwt_pkg::COUNT_OFS && clkEn && baseTimerTick
      && ctlQ[3] ##1 regRdEn && regAddr == cwt_pkg::COUNT_OFS && clkEn |=>
      regRdData[COUNT_W-1:0] inside {$past(regRdData[COUNT_W-1:0]) + 1'b1, '0}; endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step");
   property p_odd_free; quietQ == 2'h3 |-> (compareOutputEn & srQ & ODD) == '0; endproperty
   a_odd_free: assert property (p_odd_free) else $error("odd pin driven");
   property p_ch0_sr_off; quietQ == 2'h3 && ctlQ[2:0] == cwt_pkg::CLR_SEL_CH0 && srQ[0]
      |-> !compareOutputEn[0]; endproperty
   a_ch0_sr_off: assert property (p_ch0_sr_off) else $error("pair 0 driven");
   property p_sr_pair; quietQ == 2'h3 |-> (compareOutputEn & srQ & ~ODD & ~(enQ >> 1)) == '0;
   endproperty
   a_sr_pair: assert property (p_sr_pair) else $error("pair half enabled");
endmodule : cwt_timer_checker
bind cwt_timer_top cwt_timer_checker #(.NUM_CH(NUM_CH), .COUNT_W(COUNT_W)) cwt_timer_checker_inst (
   .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .baseTimerTick(baseTimerTick),
   .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regRdData(regRdData), .compareOutputPin(compareOutputPin), .compareOutputEn(compareOutputEn));

// ==== tb/tb_cwt_timer_top.sv ====
// self-checking bench for the compare waveform block
`timescale 1ns/1ps
module tb_cwt_timer_top;
   logic        sys_clk       = 1'b0;
   logic        reset         = 1'b1;
   logic        clkEn         = 1'b1;
   logic        baseTimerTick = 1'b1;
   logic [7:0]  regAddr       = 8'h00;
   logic [31:0] regWrData     = 32'h00000000;
   logic        regWrEn       = 1'b0;
   logic        regRdEn       = 1'b0;
   logic [31:0] regRdData;
   logic [7:0]  compareOutputPin;
   logic [7:0]  compareOutputEn;
   int          err_total     = 0;
   int          compares      = 0;
   int          cyc           = 0;
   always #10 sys_clk = ~sys_clk;
   cwt_timer_top cwt_timer_top_inst (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
      .baseTimerTick(baseTimerTick), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .compareOutputPin(compareOutputPin), .compareOutputEn(compareOutputEn));
   task summarize;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task rst;
      reset <= 1'b1;
      clkEn <= 1'b1;
      baseTimerTick <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
   endtask : rst
   // a gap cycle after each access keeps every strobe to one assignment per step
   task wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      // read data stands for one cycle only; take it mid-cycle
      @(negedge sys_clk);
      d = regRdData;
      @(posedge sys_clk);
   endtask : rd
   // tick widths between three pin edges, with tick and clock enable stalling at random
   task meas(input int j, output logic l1, output int d1, output int d2);
      logic last;
      int   n;
      int   cnt;
      last = compareOutputPin[j];
      n = 0;
      cnt = 0;
      d1 = -1;
      d2 = -1;
      for (int i = 0; i < 2000 && n < 3; i++) begin
         @(posedge sys_clk);
         if (compareOutputPin[j] !== last) begin
            if (n == 0) l1 = compareOutputPin[j];
            if (n == 1) d1 = cnt;
            d2 = cnt;
            n++;
            cnt = 0;
            last = compareOutputPin[j];
         end
         cnt += int'(baseTimerTick && clkEn);
         baseTimerTick <= (n == 3) || ($urandom % 4 != 0);
         clkEn <= (n == 3) || ($urandom % 4 != 0);
      end
   endtask : meas
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      logic [31:0] d, a;
      logic [7:0]  offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20,
                                 8'h40, 8'h1C, 8'h60};
      int          n, m, p, d1, d2;
      logic        l1, iv, pv, c0;
      void'($urandom(94386));
      rst();
      wr(8'h60, 32'hFFFFFFFF);
      foreach (offs[i]) begin
         rd(offs[i], d);
         chk("reset value", d, 32'h00000000);
      end
      wr(cwt_pkg::BASE_CTL_OFS, 32'h00000008);
      regAddr <= cwt_pkg::COUNT_OFS;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      a = regRdData;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      @(negedge sys_clk);
      chk("count step", regRdData, a + 32'h00000001);
      @(posedge sys_clk);
      $display("reset and count test done");
      for (int j = 0; j < 8; j++) begin
         rst();
         n = 4 + $urandom % 20;
         m = 1 + $urandom % n;
         iv = 1'($urandom);
         pv = 1'($urandom);
         wr(cwt_pkg::RELOAD_OFS, n);
         wr(cwt_pkg::CMP_BASE, n);
         wr(cwt_pkg::CMP_BASE + 8'(4 * j), m);
         wr(cwt_pkg::OUT_CTL_BASE + 8'(4 * j), 32'({pv, iv, 2'h2}));
         wr(cwt_pkg::ENABLE_OFS, 32'h00000001 << j);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("start level", 32'(d[j]), 32'(iv ^ pv));
         chk("pin enable on", 32'(d[8 + j]), 32'h00000001);
         wr(cwt_pkg::FUNC_SEL_OFS, 32'h00000001 << j);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("capture select off", 32'(d[8 + j]), 32'h00000000);
         wr(cwt_pkg::FUNC_SEL_OFS, 32'h00000000);
         wr(cwt_pkg::BASE_CTL_OFS, j[0] ? 32'h00000009 : 32'h0000000C);
         meas(j, l1, d1, d2);
         chk("first width", d1, n + 2);
         chk("second width", d2, n + 2);
         rd(cwt_pkg::FLAGS_OFS, d);
         chk("match flag", 32'(d[j]), 32'h00000001);
         wr(cwt_pkg::ENABLE_OFS, 32'h00000000);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("pin enable off", 32'(d[8 + j]), 32'h00000000);
         $display("toggle test done on channel %0d", j);
      end
      for (int j = 0; j < 8; j += 2) begin
         rst();
         p = 8 + $urandom % 20;
         m = 1 + $urandom % (p - 2);
         n = m + 1 + $urandom % (p - m - 1);
         pv = 1'($urandom);
         c0 = (j == 0) || (j == 4);
         wr(cwt_pkg::RELOAD_OFS, p);
         wr(cwt_pkg::CMP_BASE, p);
         wr(cwt_pkg::CMP_BASE + 8'(4 * j), m);
         wr(cwt_pkg::CMP_BASE + 8'(4 * j + 4), n);
         wr(cwt_pkg::OUT_CTL_BASE + 8'(4 * j), 32'({pv, 3'h1}));
         wr(cwt_pkg::OUT_CTL_BASE + 8'(4 * j + 4), 32'h00000001);
         wr(cwt_pkg::BASE_CTL_OFS, c0 ? 32'h00000009 : 32'h0000000C);
         wr(cwt_pkg::ENABLE_OFS, 32'h00000001 << j);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("half pair enable", 32'(d[8 + j]), 32'h00000000);
         wr(cwt_pkg::ENABLE_OFS, 32'h00000003 << j);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("pair enable", 32'(d[8 + j]), 32'(j != 0));
         chk("odd pin free", 32'(d[9 + j]), 32'h00000000);
         if (j != 0) begin
            meas(j, l1, d1, d2);
            chk("active width", (l1 != pv) ? d1 : d2, n - m);
            chk("period", d1 + d2, p + 2);
            rd(cwt_pkg::FLAGS_OFS, d);
            chk("pair flags", 32'(d[j +: 2]), 32'h00000003);
         end
         wr(cwt_pkg::ENABLE_OFS, 32'h00000000);
         rd(cwt_pkg::PIN_STATE_OFS, d);
         chk("pair off", 32'(d[8 + j]), 32'h00000000);
         $display("set and clear test done on pair %0d", j);
      end
      summarize();
   end
endmodule : tb_cwt_timer_top

// ==== verilog/cwt_chan_if.sv ====
// per-channel bundle between the timer core and one waveform channel
`timescale 1ns/1ps
interface cwt_chan_if;
   logic [15:0]        count;
   logic               tick;
   logic [15:0]        cmpValue;
   cwt_pkg::cwt_mode_t mode;
   logic               initLevel;
   logic               polarity;
   logic               enable;
   logic               pairEnable;
   logic               funcSel;
   logic               blockSr;
   logic               partnerMatch;
   logic               match;
   logic               pin;
   logic               pinEn;

   modport core (output count, tick, cmpValue, mode, initLevel, polarity, enable,
                 pairEnable, funcSel, blockSr, partnerMatch,
                 input match, pin, pinEn);
   modport chan (input count, tick, cmpValue, mode, initLevel, polarity, enable,
                 pairEnable, funcSel, blockSr, partnerMatch,
                 output match, pin, pinEn);
endinterface : cwt_chan_if

// ==== verilog/cwt_channel.sv ====
// one compare channel: match detect and waveform state
`timescale 1ns/1ps
module cwt_channel #(
   parameter bit IS_EVEN = 1'b1
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clkEn,
   cwt_chan_if.chan ch
);
   typedef struct packed {
      logic wave;
      logic pin;
      logic pinEn;
   } cwt_chan_state_t;

   cwt_chan_state_t stateQ;
   cwt_chan_state_t stateD;
   logic            active;
   logic            srOk;

   // one pulse per counted value, never per clock
   assign ch.match = ch.tick && ch.enable && !ch.funcSel
                     && (ch.count == ch.cmpValue);
   assign ch.pin   = stateQ.pin;
   assign ch.pinEn = stateQ.pinEn;

   always_comb begin
      stateD = stateQ;
      active = ch.enable && !ch.funcSel;
      // pair runs only with both enables; pair 0/1 blocked when ch0 clears the timer
      srOk   = IS_EVEN && (ch.mode == cwt_pkg::CWT_MODE_SR) && active
               && ch.pairEnable && !ch.blockSr;
      if (!active) begin
         stateD.wave = ch.initLevel;
      end else begin
         case (ch.mode)
            cwt_pkg::CWT_MODE_PHASE: begin
               if (ch.match) begin
                  stateD.wave = !stateQ.wave;
               end
            end
            cwt_pkg::CWT_MODE_SR: begin
               if (!srOk) begin
                  stateD.wave = ch.initLevel;
               end else if (ch.match) begin
                  stateD.wave = !ch.initLevel;
               end else if (ch.partnerMatch) begin
                  stateD.wave = ch.initLevel;
               end
            end
            default: begin
               stateD.wave = stateQ.wave;
            end
         endcase
      end
      // odd pin of a pair stays free; single-phase is not built here
      stateD.pinEn = active && ((ch.mode == cwt_pkg::CWT_MODE_PHASE) || srOk);
      stateD.pin   = stateD.wave ^ ch.polarity;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stateQ <= '0;
      end else if (clkEn) begin
         stateQ <= stateD;
      end
   end
endmodule : cwt_channel

// ==== verilog/cwt_pkg.sv ====
// shared constants and types for the compare waveform block
package cwt_pkg;
   localparam int unsigned NUM_CH   = 8;
   localparam int unsigned COUNT_W  = 16;
   localparam int unsigned ADDR_W   = 8;

   // register byte offsets and the bank mask
   localparam logic [7:0] BASE_CTL_OFS   = 8'h00;
   localparam logic [7:0] RELOAD_OFS     = 8'h04;
   localparam logic [7:0] ENABLE_OFS     = 8'h08;
   localparam logic [7:0] FUNC_SEL_OFS   = 8'h0C;
   localparam logic [7:0] FLAGS_OFS      = 8'h10;
   localparam logic [7:0] COUNT_OFS      = 8'h14;
   localparam logic [7:0] PIN_STATE_OFS  = 8'h18;
   localparam logic [7:0] OUT_CTL_BASE   = 8'h20;
   localparam logic [7:0] CMP_BASE       = 8'h40;
   localparam logic [7:0] BANK_MASK      = 8'hE0;

   // base control fields
   localparam int unsigned CLR_CH0_BIT    = 0;
   localparam int unsigned CLR_ALT_BIT    = 1;
   localparam int unsigned CLR_RELOAD_BIT = 2;
   localparam int unsigned RUN_BIT        = 3;
   localparam logic [2:0]  CLR_SEL_CH0    = 3'h1;
   localparam logic [2:0]  CLR_SEL_RELOAD = 3'h4;

   // channel output control fields
   localparam int unsigned MODE_LSB       = 0;
   localparam int unsigned INIT_LEVEL_BIT = 2;
   localparam int unsigned POLARITY_BIT   = 3;

   // reset values and the count step
   localparam logic [3:0]  BASE_CTL_RST = 4'h0;
   localparam logic [15:0] RELOAD_RST   = 16'h0000;
   localparam logic [15:0] CMP_RST      = 16'h0000;
   localparam logic [3:0]  OUT_CTL_RST  = 4'h0;
   localparam logic [7:0]  BANK_RST     = 8'h00;
   localparam logic [15:0] COUNT_RST    = 16'h0000;
   localparam logic [15:0] COUNT_STEP   = 16'h0001;

   typedef enum logic [1:0] {
      CWT_MODE_SINGLE = 2'h0,
      CWT_MODE_SR     = 2'h1,
      CWT_MODE_PHASE  = 2'h2,
      CWT_MODE_RSVD   = 2'h3
   } cwt_mode_t;
endpackage : cwt_pkg

// ==== verilog/cwt_timer_top.sv ====
// base timer, register port and eight compare waveform channels
`timescale 1ns/1ps
// What this block does
// - phase-delayed mode flips a channel pin on every compare match.
// - free-running phase-delayed halves each last 65536 timer counts.
// - with clearing, phase-delayed halves last n+2 counts each.
// - channel-0 clear bit alone clears the timer on channel 0 match.
// - reload-clear bit alone clears the timer on reload value match.
// - enable bit written 1 starts channel output, 0 stops it.
// - phase-delayed match sets that channel's match flag.
// - per-channel initial level sets the starting waveform level.
// - per-channel polarity option complements the waveform at the pin.
// - set/reset: even match drives the inverse of the initial level, next odd match drives the initial level.
// - set/reset free-running: period 65536, active width n minus m.
// - set/reset with clearing: period p+2, active width n minus m.
// - set/reset runs only with both pair enables set.
// - set/reset flags: even match sets even flag, odd sets odd flag.
// - channel-0 clearing disables set/reset on the channel 0/1 pair.
// - set/reset waveform only on even pin; odd pin left free.
module cwt_timer_top #(
   parameter int unsigned NUM_CH  = cwt_pkg::NUM_CH,
   parameter int unsigned COUNT_W = cwt_pkg::COUNT_W
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              clkEn,
   input  wire logic              baseTimerTick,
   input  wire logic [7:0]        regAddr,
   input  wire logic [31:0]       regWrData,
   input  wire logic              regWrEn,
   input  wire logic              regRdEn,
   output logic      [31:0]       regRdData,
   output logic      [NUM_CH-1:0] compareOutputPin,
   output logic      [NUM_CH-1:0] compareOutputEn
);
   typedef struct packed {
      logic [COUNT_W-1:0]             count;
      logic [3:0]                     baseCtl;
      logic [COUNT_W-1:0]             reload;
      logic [NUM_CH-1:0]              enable;
      logic [NUM_CH-1:0]              funcSel;
      logic [NUM_CH-1:0]              flags;
      logic [NUM_CH-1:0][3:0]         outCtl;
      logic [NUM_CH-1:0][COUNT_W-1:0] cmp;
      logic [31:0]                    rdData;
   } cwt_top_state_t;

   cwt_top_state_t     stateQ;
   cwt_top_state_t     stateD;
   logic [NUM_CH-1:0]  match;
   logic [NUM_CH-1:0]  pinVal;
   logic [NUM_CH-1:0]  pinEnVal;
   logic [2:0]         clrSel;
   logic               clrOnCh0;
   logic               clrOnReload;
   logic [COUNT_W-1:0] clrTop;
   logic [NUM_CH-1:0]  flagClr;
   logic [2:0]         chIdx;
   logic [7:0]         bank;

   cwt_chan_if chIf [NUM_CH] ();

   // clear source decode: only the exact ch0 and reload single-bit patterns clear
   assign clrSel      = {stateQ.baseCtl[cwt_pkg::CLR_RELOAD_BIT],
                         stateQ.baseCtl[cwt_pkg::CLR_ALT_BIT],
                         stateQ.baseCtl[cwt_pkg::CLR_CH0_BIT]};
   assign clrOnCh0    = (clrSel == cwt_pkg::CLR_SEL_CH0);
   assign clrOnReload = (clrSel == cwt_pkg::CLR_SEL_RELOAD);
   assign clrTop      = clrOnCh0 ? stateQ.cmp[0] : stateQ.reload;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         assign chIf[gi].count      = stateQ.count;
         assign chIf[gi].tick       = baseTimerTick && stateQ.baseCtl[cwt_pkg::RUN_BIT];
         assign chIf[gi].cmpValue   = stateQ.cmp[gi];
         assign chIf[gi].mode       = cwt_pkg::cwt_mode_t'(stateQ.outCtl[gi][1:0]);
         assign chIf[gi].initLevel  = stateQ.outCtl[gi][cwt_pkg::INIT_LEVEL_BIT];
         assign chIf[gi].polarity   = stateQ.outCtl[gi][cwt_pkg::POLARITY_BIT];
         assign chIf[gi].enable     = stateQ.enable[gi];
         assign chIf[gi].funcSel    = stateQ.funcSel[gi];
         assign chIf[gi].blockSr    = (gi == 0) && clrOnCh0;
         if ((gi % 2) == 0) begin : g_even
            assign chIf[gi].pairEnable   = stateQ.enable[gi+1];
            assign chIf[gi].partnerMatch = chIf[gi+1].match;
         end else begin : g_odd
            assign chIf[gi].pairEnable   = 1'b0;
            assign chIf[gi].partnerMatch = 1'b0;
         end
         assign match[gi]    = chIf[gi].match;
         assign pinVal[gi]   = chIf[gi].pin;
         assign pinEnVal[gi] = chIf[gi].pinEn;

         cwt_channel #(
            .IS_EVEN ((gi % 2) == 0)
         ) u_chan (
            .sys_clk (sys_clk),
            .reset   (reset),
            .clkEn   (clkEn),
            .ch      (chIf[gi])
         );
      end
   endgenerate

   assign compareOutputPin = pinVal;
   assign compareOutputEn  = pinEnVal;
   assign regRdData        = stateQ.rdData;

   always_comb begin
      stateD  = stateQ;
      chIdx   = regAddr[4:2];
      bank    = regAddr & cwt_pkg::BANK_MASK;
      flagClr = '0;
      stateD.rdData = '0;

      // base timer; clearing lands one count past the top, so the
      // period is top+2 counts
      if (baseTimerTick && stateQ.baseCtl[cwt_pkg::RUN_BIT]) begin
         if ((clrOnCh0 || clrOnReload)
             && (stateQ.count == COUNT_W'(clrTop + cwt_pkg::COUNT_STEP))) begin
            stateD.count = cwt_pkg::COUNT_RST;
         end else begin
            stateD.count = COUNT_W'(stateQ.count + cwt_pkg::COUNT_STEP);
         end
      end

      if (regWrEn) begin
         // word-aligned slots only; index spans all eight channels
         if (bank == cwt_pkg::OUT_CTL_BASE) begin
            if (regAddr[1:0] == 2'h0) begin
               stateD.outCtl[chIdx] = regWrData[3:0];
            end
         end else if (bank == cwt_pkg::CMP_BASE) begin
            if (regAddr[1:0] == 2'h0) begin
               stateD.cmp[chIdx] = regWrData[COUNT_W-1:0];
            end
         end else begin
            case (regAddr)
               cwt_pkg::BASE_CTL_OFS: stateD.baseCtl = regWrData[3:0];
               cwt_pkg::RELOAD_OFS:   stateD.reload  = regWrData[COUNT_W-1:0];
               cwt_pkg::ENABLE_OFS:   stateD.enable  = regWrData[NUM_CH-1:0];
               cwt_pkg::FUNC_SEL_OFS: stateD.funcSel = regWrData[NUM_CH-1:0];
               cwt_pkg::FLAGS_OFS:    flagClr        = regWrData[NUM_CH-1:0];
               default: begin
                  stateD.rdData = '0;
               end
            endcase
         end
      end

      // a match in the clearing cycle wins over the clear
      stateD.flags = (stateQ.flags & ~flagClr) | match;

      if (regRdEn) begin
         if ((bank == cwt_pkg::OUT_CTL_BASE) && (regAddr[1:0] == 2'h0)) begin
            stateD.rdData = {28'h0000000, stateQ.outCtl[chIdx]};
         end else if ((bank == cwt_pkg::CMP_BASE) && (regAddr[1:0] == 2'h0)) begin
            stateD.rdData = {16'h0000, stateQ.cmp[chIdx]};
         end else begin
            case (regAddr)
               cwt_pkg::BASE_CTL_OFS:  stateD.rdData = {28'h0000000, stateQ.baseCtl};
               cwt_pkg::RELOAD_OFS:    stateD.rdData = {16'h0000, stateQ.reload};
               cwt_pkg::ENABLE_OFS:    stateD.rdData = {24'h000000, stateQ.enable};
               cwt_pkg::FUNC_SEL_OFS:  stateD.rdData = {24'h000000, stateQ.funcSel};
               cwt_pkg::FLAGS_OFS:     stateD.rdData = {24'h000000, stateQ.flags};
               cwt_pkg::COUNT_OFS:     stateD.rdData = {16'h0000, stateQ.count};
               cwt_pkg::PIN_STATE_OFS: stateD.rdData = {16'h0000, pinEnVal, pinVal};
               default: begin
                  stateD.rdData = '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stateQ.count   <= cwt_pkg::COUNT_RST;
         stateQ.baseCtl <= cwt_pkg::BASE_CTL_RST;
         stateQ.reload  <= cwt_pkg::RELOAD_RST;
         stateQ.enable  <= cwt_pkg::BANK_RST;
         stateQ.funcSel <= cwt_pkg::BANK_RST;
         stateQ.flags   <= cwt_pkg::BANK_RST;
         stateQ.outCtl  <= '0;
         stateQ.cmp     <= '0;
         stateQ.rdData  <= '0;
      end else if (clkEn) begin
         stateQ <= stateD;
      end
   end
endmodule : cwt_timer_top
